// ==== verilog/ssops_core.sv ====
// ssops_core: subtract instructions and the sleep instruction of an 8-bit core.
// assumes the decoder supplies the op, the file operand already read, and takes file writes back.
//
// What this block does
// RQ1: literal subtract writes literal minus accumulator into the accumulator.
// RQ2: literal subtract: carry clears when accumulator is larger, nibble carry when its low nibble is larger.
// RQ3: sleep clears watchdog counter and its prescaler.
// RQ4: sleep drives power-down flag low and time-out flag high (both active low).
// RQ5: on the edge that updates the flags, sleep halts the oscillator and enters low power.
// RQ6: file subtract: file minus accumulator, destination bit picks accumulator or file.
// RQ7: file subtract updates carry, nibble carry on comparisons, and zero.
// RQ8: subtract with borrow also removes inverted carry; destination and flags as above.
// RQ9: every subtract sets zero when the 8-bit result is zero.
module ssops_core
   import ssops_pkg::*;
(
   input  wire logic                 CLK_I,
   input  wire logic                 RESET_I,
   input  wire logic                 OP_VALID_I,
   input  wire ssops_op_type         OP_I,
   input  wire logic [DATA_W-1:0]    LITERAL_I,
   input  wire logic [FADDR_W-1:0]   FILE_ADDR_I,
   input  wire logic [DATA_W-1:0]    FILE_DATA_I,
   input  wire logic                 DEST_I,
   input  wire logic                 WAKE_I,
   input  wire logic                 WDT_TICK_I,
   output logic [DATA_W-1:0]         ACC_O,
   output logic                      CARRY_O,
   output logic                      NIBBLE_CARRY_O,
   output logic                      ZERO_O,
   output logic                      FILE_WE_O,
   output logic [FADDR_W-1:0]        FILE_WADDR_O,
   output logic [DATA_W-1:0]         FILE_WDATA_O,
   output logic [WDT_W-1:0]          WATCHDOG_COUNTER_O,
   output logic [WDT_PRE_W-1:0]      WDT_PRESCALER_O,
   output logic                      POWER_DOWN_FLAG_N_O,
   output logic                      WATCHDOG_EXPIRY_FLAG_N_O,
   output logic                      OSC_RUN_O,
   output logic                      ASLEEP_O
);
   ssops_alu_if alu_bus ();

   ssops_sub u_sub (
      .bus (alu_bus.alu)
   );

   logic [DATA_W-1:0]    acc_q;
   logic                 carry_q;
   logic                 nib_q;
   logic                 zero_q;
   logic                 fwe_q;
   logic [FADDR_W-1:0]   fwaddr_q;
   logic [DATA_W-1:0]    fwdata_q;
   logic [WDT_W-1:0]     wdt_q;
   logic [WDT_PRE_W-1:0] pre_q;
   logic                 pwrdn_n_q;
   logic                 expiry_n_q;
   logic                 osc_run_q;
   logic                 asleep_q;
   ssops_state_type      state_q;
   ssops_state_type      state_d;
   logic [DATA_W-1:0]    acc_d;
   logic                 carry_d;
   logic                 nib_d;
   logic                 zero_d;
   logic [FADDR_W-1:0]   fwaddr_d;
   logic [DATA_W-1:0]    fwdata_d;
   logic [WDT_W-1:0]     wdt_d;
   logic [WDT_PRE_W-1:0] pre_d;
   logic                 pwrdn_n_d;
   logic                 expiry_n_d;

   // both file forms share operand routing and destination handling
   function automatic logic ssops_file_form(input ssops_op_type op);
      return (op == SSOPS_FILE_SUB) || (op == SSOPS_FILE_SUB_BORROW);
   endfunction

   wire running    = (state_q == SSOPS_RUN);
   wire do_op      = running & OP_VALID_I;
   wire is_lit     = do_op & (OP_I == SSOPS_LIT_SUB);
   wire is_fkind   = do_op & ssops_file_form(OP_I);
   wire is_borrow  = do_op & (OP_I == SSOPS_FILE_SUB_BORROW);
   wire is_sleep   = do_op & (OP_I == SSOPS_SLEEP);
   wire is_sub     = is_lit | is_fkind;
   wire to_acc     = is_lit | (is_fkind & (DEST_I == DEST_ACC)); // RQ6 RQ8
   wire to_file    = is_fkind & (DEST_I != DEST_ACC);              // RQ6 RQ8
   wire pre_wrap   = (pre_q == {WDT_PRE_W{1'b1}});

   // operand order: minuend is literal or file, subtrahend is always the accumulator
   assign alu_bus.minuend    = is_lit ? LITERAL_I : FILE_DATA_I; // RQ1 RQ6
   assign alu_bus.subtrahend = acc_q;
   // borrow reads the registered carry, so chained borrow ops see the previous result
   assign alu_bus.borrow_in  = is_borrow & ~carry_q;             // RQ8

   // next values are chosen here; the clocked blocks below only load them
   assign acc_d    = to_acc ? alu_bus.result : acc_q;            // RQ1 RQ6 RQ8
   assign carry_d  = is_sub ? alu_bus.carry : carry_q;           // RQ2 RQ7 RQ8
   assign nib_d    = is_sub ? alu_bus.nibble_carry : nib_q;      // RQ2 RQ7 RQ8
   assign zero_d   = is_sub ? alu_bus.zero : zero_q;             // RQ9
   assign fwaddr_d = to_file ? FILE_ADDR_I : fwaddr_q;           // RQ6 RQ8
   assign fwdata_d = to_file ? alu_bus.result : fwdata_q;        // RQ6 RQ8

   // the prescaler carries into the counter only on the tick that wraps it
   wire [WDT_PRE_W-1:0] pre_inc  = pre_q + 8'h01;
   wire [WDT_W-1:0]     wdt_inc  = wdt_q + 8'h01;
   wire                 wdt_step = WDT_TICK_I & pre_wrap;
   assign pre_d = is_sleep ? PRE_CLEAR : (WDT_TICK_I ? pre_inc : pre_q); // RQ3
   assign wdt_d = is_sleep ? WDT_CLEAR : (wdt_step ? wdt_inc : wdt_q);   // RQ3

   // both status flags are active low; only a reset brings power-down back high
   assign pwrdn_n_d  = is_sleep ? 1'b0 : pwrdn_n_q;  // RQ4
   assign expiry_n_d = is_sleep ? 1'b1 : expiry_n_q; // RQ4

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         acc_q <= ACC_RST;
      end else begin
         acc_q <= acc_d;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         carry_q <= CARRY_RST;
         nib_q   <= NIBBLE_RST;
         zero_q  <= ZERO_RST;
      end else begin
         carry_q <= carry_d;
         nib_q   <= nib_d;
         zero_q  <= zero_d;
      end
   end

   // file write is a one-cycle strobe the decoder commits to the register file
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         fwe_q    <= 1'b0;
         fwaddr_q <= {FADDR_W{1'b0}};
         fwdata_q <= ACC_RST;
      end else begin
         fwe_q    <= to_file; // RQ6 RQ8
         fwaddr_q <= fwaddr_d;
         fwdata_q <= fwdata_d;
      end
   end

   // watchdog keeps ticking in sleep; only sleep entry or reset clears it
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         wdt_q <= WDT_CLEAR;
         pre_q <= PRE_CLEAR;
      end else begin
         wdt_q <= wdt_d;
         pre_q <= pre_d;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         pwrdn_n_q  <= PWRDN_N_RST;
         expiry_n_q <= EXPIRY_N_RST;
      end else begin
         pwrdn_n_q  <= pwrdn_n_d;
         expiry_n_q <= expiry_n_d;
      end
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         SSOPS_RUN: begin
            if (is_sleep) begin
               state_d = SSOPS_ASLEEP; // RQ5
            end
         end
         SSOPS_ASLEEP: begin
            if (WAKE_I) begin
               state_d = SSOPS_RUN;
            end
         end
         default: begin
            state_d = SSOPS_RUN;
         end
      endcase
   end

   wire asleep_d = (state_d == SSOPS_ASLEEP);

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         state_q <= SSOPS_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // flags land on the same edge as the state change, which is also the edge that drops the oscillator run
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         osc_run_q <= 1'b1;
         asleep_q  <= 1'b0;
      end else begin
         osc_run_q <= ~asleep_d; // RQ5
         asleep_q  <= asleep_d;
      end
   end

   // every port comes straight from a register
   assign ACC_O                    = acc_q;
   assign CARRY_O                  = carry_q;
   assign NIBBLE_CARRY_O           = nib_q;
   assign ZERO_O                   = zero_q;
   assign FILE_WE_O                = fwe_q;
   assign FILE_WADDR_O             = fwaddr_q;
   assign FILE_WDATA_O             = fwdata_q;
   assign WATCHDOG_COUNTER_O       = wdt_q;
   assign WDT_PRESCALER_O          = pre_q;
   assign POWER_DOWN_FLAG_N_O      = pwrdn_n_q;
   assign WATCHDOG_EXPIRY_FLAG_N_O = expiry_n_q;
   assign OSC_RUN_O                = osc_run_q;
   assign ASLEEP_O                 = asleep_q;
endmodule // ssops_core

// ==== pkg/ssops_pkg.sv ====
// ssops_pkg: operation codes, flag reset values and field widths for the subtract/sleep unit.
// assumes the instruction decoder presents one operation per clock with operands already fetched.
package ssops_pkg;
   localparam int DATA_W     = 8;
   localparam int FADDR_W    = 7;
   localparam int NIB_W      = 4;
   localparam int WDT_W      = 8;
   localparam int WDT_PRE_W  = 8;

   localparam logic [DATA_W-1:0]    ACC_RST      = 8'h00;
   localparam logic [WDT_W-1:0]     WDT_CLEAR    = 8'h00;
   localparam logic [WDT_PRE_W-1:0] PRE_CLEAR    = 8'h00;
   localparam logic                 CARRY_RST    = 1'b0;
   localparam logic                 NIBBLE_RST   = 1'b0;
   localparam logic                 ZERO_RST     = 1'b0;
   localparam logic                 PWRDN_N_RST  = 1'b1;
   localparam logic                 EXPIRY_N_RST = 1'b1;
   localparam logic                 DEST_ACC     = 1'b0;

   typedef enum logic [2:0] {
      SSOPS_NOP,
      SSOPS_LIT_SUB,
      SSOPS_FILE_SUB,
      SSOPS_FILE_SUB_BORROW,
      SSOPS_SLEEP
   } ssops_op_type;

   typedef enum {
      SSOPS_RUN,
      SSOPS_ASLEEP
   } ssops_state_type;
endpackage

// ==== pkg/ssops_alu_if.sv ====
// ssops_alu_if: operands and results passed between the core control and the subtractor.
// assumes both ends sit on the same clock; the subtractor is purely combinational.
interface ssops_alu_if;
   import ssops_pkg::*;
   logic [DATA_W-1:0] minuend;
   logic [DATA_W-1:0] subtrahend;
   logic              borrow_in;
   logic [DATA_W-1:0] result;
   logic              carry;
   logic              nibble_carry;
   logic              zero;

   modport ctrl (output minuend, output subtrahend, output borrow_in,
                 input result, input carry, input nibble_carry, input zero);
   modport alu  (input minuend, input subtrahend, input borrow_in,
                 output result, output carry, output nibble_carry, output zero);
endinterface

// ==== verilog/ssops_sub.sv ====
// ssops_sub: 8-bit two's complement subtractor with borrow in, carry, nibble carry and zero out.
// assumes borrow_in is 1 when a borrow is pending (inverted carry); 0 for plain subtract.
module ssops_sub
   import ssops_pkg::*;
(
   ssops_alu_if.alu bus
);
   // add with inverted subtrahend: carry out high means no borrow
   wire [DATA_W:0]  full_sum;
   wire [NIB_W:0]   nib_sum;
   wire             cin;

   assign cin      = ~bus.borrow_in;
   assign full_sum = {1'b0, bus.minuend} + {1'b0, ~bus.subtrahend} + {{DATA_W{1'b0}}, cin};
   assign nib_sum  = {1'b0, bus.minuend[NIB_W-1:0]} + {1'b0, ~bus.subtrahend[NIB_W-1:0]}
                   + {{NIB_W{1'b0}}, cin};

   assign bus.result       = full_sum[DATA_W-1:0];
   assign bus.carry        = full_sum[DATA_W];   // RQ2 RQ7
   assign bus.nibble_carry = nib_sum[NIB_W];     // RQ2 RQ7
   assign bus.zero         = (full_sum[DATA_W-1:0] == 8'h00); // RQ9
endmodule // ssops_sub

// ==== tb/ssops_decoder_model.sv ====
// ssops_decoder_model: file register store that feeds operands to the subtract/sleep unit.
// assumes file register a starts holding a; unit writes land on the next edge.
module ssops_decoder_model
   import ssops_pkg::*;
(
   input  wire logic               CLK_I,
   input  wire logic               FILE_WE_O,
   input  wire logic [FADDR_W-1:0] FILE_WADDR_O,
   input  wire logic [DATA_W-1:0]  FILE_WDATA_O,
   input  wire logic [FADDR_W-1:0] FILE_ADDR_I,
   output logic      [DATA_W-1:0]  FILE_DATA_I
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W-1:0] mem [128];
   initial for (int i = 0; i < 128; i++) mem[i] = 8'(i);
   always @(posedge CLK_I) if (FILE_WE_O) mem[FILE_WADDR_O] <= FILE_WDATA_O;
   // forward a pending write, else a back-to-back op would read stale data
   assign FILE_DATA_I = (FILE_WE_O && FILE_WADDR_O == FILE_ADDR_I) ? FILE_WDATA_O
                        : mem[FILE_ADDR_I];
endmodule // ssops_decoder_model

// ==== tb/ssops_core_checker.sv ====
// ssops_core_checker: port assertions for ssops_core.
// assumes one clock, synchronous active-high reset.
module ssops_core_checker
   import ssops_pkg::*;
(
   input wire logic                 CLK_I,
   input wire logic                 RESET_I,
   input wire logic                 OP_VALID_I,
   input wire ssops_op_type         OP_I,
   input wire logic [DATA_W-1:0]    LITERAL_I,
   input wire logic [DATA_W-1:0]    FILE_DATA_I,
   input wire logic                 DEST_I,
   input wire logic [DATA_W-1:0]    ACC_O,
   input wire logic                 CARRY_O,
   input wire logic                 NIBBLE_CARRY_O,
   input wire logic                 ZERO_O,
   input wire logic                 FILE_WE_O,
   input wire logic [DATA_W-1:0]    FILE_WDATA_O,
   input wire logic [WDT_W-1:0]     WATCHDOG_COUNTER_O,
   input wire logic [WDT_PRE_W-1:0] WDT_PRESCALER_O,
   input wire logic                 POWER_DOWN_FLAG_N_O,
   input wire logic                 WATCHDOG_EXPIRY_FLAG_N_O,
   input wire logic                 OSC_RUN_O,
   input wire logic                 ASLEEP_O
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RESET_I);
   wire go = OP_VALID_I && !ASLEEP_O;
   wire is_sub = go && OP_I inside {SSOPS_LIT_SUB, SSOPS_FILE_SUB, SSOPS_FILE_SUB_BORROW};
   wire sleep = go && OP_I == SSOPS_SLEEP;
   lit_result_a: assert property (go && OP_I == SSOPS_LIT_SUB
      |=> ACC_O == $past(LITERAL_I) - $past(ACC_O)) else $error("literal result");
   lit_carry_a: assert property (go && OP_I == SSOPS_LIT_SUB
      |=> CARRY_O == ($past(ACC_O) <= $past(LITERAL_I))
      && NIBBLE_CARRY_O == ($past(ACC_O[3:0]) <= $past(LITERAL_I[3:0])))
      else $error("literal carries");
   wdt_clear_a: assert property (sleep |=> WATCHDOG_COUNTER_O == WDT_CLEAR
      && WDT_PRESCALER_O == PRE_CLEAR) else $error("watchdog not cleared");
   sleep_flags_a: assert property (sleep
      |=> !POWER_DOWN_FLAG_N_O && WATCHDOG_EXPIRY_FLAG_N_O) else $error("sleep flags");
   osc_halt_a: assert property (sleep
      |=> !OSC_RUN_O && ASLEEP_O) else $error("oscillator still running");
   file_write_a: assert property (go && OP_I == SSOPS_FILE_SUB && DEST_I
      |=> FILE_WE_O && FILE_WDATA_O == $past(FILE_DATA_I) - $past(ACC_O)
      && ACC_O == $past(ACC_O)) else $error("file write");
   file_carry_a: assert property (go && OP_I == SSOPS_FILE_SUB
      |=> CARRY_O == ($past(ACC_O) <= $past(FILE_DATA_I))
      && NIBBLE_CARRY_O == ($past(ACC_O[3:0]) <= $past(FILE_DATA_I[3:0])))
      else $error("file carries");
   borrow_acc_a: assert property (go && OP_I == SSOPS_FILE_SUB_BORROW && !DEST_I
      |=> ACC_O == $past(FILE_DATA_I) - $past(ACC_O) - {7'h00, !$past(CARRY_O)})
      else $error("borrow result");
   borrow_carry_a: assert property (go && OP_I == SSOPS_FILE_SUB_BORROW
      |=> CARRY_O == (({1'b0, $past(ACC_O)} + {8'h00, !$past(CARRY_O)})
                      <= {1'b0, $past(FILE_DATA_I)}))
      else $error("borrow carry");
   zero_flag_a: assert property (is_sub
      |=> ZERO_O == ((FILE_WE_O ? FILE_WDATA_O : ACC_O) == 8'h00)) else $error("zero flag");
   c_sleep: cover property (sleep);
   c_borrow: cover property (go && OP_I == SSOPS_FILE_SUB_BORROW && !CARRY_O);
   c_file: cover property (go && OP_I == SSOPS_FILE_SUB && DEST_I);
endmodule // ssops_core_checker

bind ssops_core ssops_core_checker chk (.*);

// ==== tb/testbench.sv ====
// testbench: directed subtract and sleep checks on ssops_core.
// assumes the decoder model preloads file register a with a.
module testbench
   import ssops_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK_I, RESET_I, OP_VALID_I, DEST_I, WAKE_I, WDT_TICK_I, CARRY_O, NIBBLE_CARRY_O;
   logic ZERO_O, FILE_WE_O, POWER_DOWN_FLAG_N_O, WATCHDOG_EXPIRY_FLAG_N_O, OSC_RUN_O, ASLEEP_O;
   ssops_op_type OP_I;
   logic [DATA_W-1:0] LITERAL_I, FILE_DATA_I, ACC_O, FILE_WDATA_O;
   logic [WDT_W-1:0] WATCHDOG_COUNTER_O, WDT_PRESCALER_O;
   logic [FADDR_W-1:0] FILE_ADDR_I, FILE_WADDR_O;
   int errors, compares;
   ssops_core dut (.*);
   ssops_decoder_model model (.*);
   always #2.5 CLK_I = ~CLK_I;
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic run(ssops_op_type o, logic [7:0] k, logic [6:0] a, logic d);
      // one idle edge first, so back-to-back calls never retoggle the valid strobe
      @(posedge CLK_I) #1;
      OP_I = o;
      LITERAL_I = k;
      FILE_ADDR_I = a;
      DEST_I = d;
      OP_VALID_I = 1'b1;
      @(posedge CLK_I) #1;
      OP_VALID_I = 1'b0;
   endtask
   // result check: accumulator and carry, nibble carry, zero packed low
   task automatic res(logic [7:0] acc, logic [2:0] czd);
      chk("acc", acc, ACC_O);
      chk("flags", {5'h00, czd}, {5'h00, CARRY_O, NIBBLE_CARRY_O, ZERO_O});
   endtask
   task automatic lit_scn();
      run(SSOPS_LIT_SUB, 8'h05, 7'h00, 1'b0);
      res(8'h05, 3'h6);
      run(SSOPS_LIT_SUB, 8'h03, 7'h00, 1'b0);
      res(8'hfe, 3'h0);
      run(SSOPS_LIT_SUB, 8'hfe, 7'h00, 1'b0);
      res(8'h00, 3'h7);
   endtask
   task automatic file_scn();
      run(SSOPS_FILE_SUB, 8'h00, 7'h7f, 1'b1);
      res(8'h00, 3'h6);
      chk("we addr", 8'hff, {FILE_WE_O, FILE_WADDR_O});
      chk("wdata", 8'h7f, FILE_WDATA_O);
      run(SSOPS_FILE_SUB, 8'h00, 7'h7f, 1'b0);
      res(8'h7f, 3'h6);
      chk("we", 8'h00, FILE_WE_O);
      run(SSOPS_FILE_SUB, 8'h00, 7'h08, 1'b0);
      res(8'h89, 3'h0);
   endtask
   task automatic borrow_scn();
      run(SSOPS_FILE_SUB_BORROW, 8'h00, 7'h08, 1'b0);
      res(8'h7e, 3'h0);
      run(SSOPS_FILE_SUB_BORROW, 8'h00, 7'h7f, 1'b1);
      res(8'h7e, 3'h7);
      chk("wdata", 8'h00, FILE_WDATA_O);
      run(SSOPS_FILE_SUB_BORROW, 8'h00, 7'h7e, 1'b0);
      res(8'h00, 3'h7);
   endtask
   task automatic sleep_scn();
      WDT_TICK_I = 1'b1;
      repeat (259) @(posedge CLK_I) #1;
      WDT_TICK_I = 1'b0;
      // 259 ticks: one prescaler wrap into the counter, three left over
      chk("wdt count", 8'h01, WATCHDOG_COUNTER_O);
      chk("prescaler", 8'h03, WDT_PRESCALER_O);
      run(SSOPS_SLEEP, 8'h00, 7'h00, 1'b0);
      chk("wdt pre", 8'h00, WATCHDOG_COUNTER_O | WDT_PRESCALER_O);
      chk("sleep flags", 8'h01, {6'h00, POWER_DOWN_FLAG_N_O, WATCHDOG_EXPIRY_FLAG_N_O});
      chk("osc sleep", 8'h01, {6'h00, OSC_RUN_O, ASLEEP_O});
      run(SSOPS_LIT_SUB, 8'h01, 7'h00, 1'b0);
      chk("acc", 8'h00, ACC_O);
      WAKE_I = 1'b1;
      @(posedge CLK_I) #1;
      WAKE_I = 1'b0;
      chk("osc sleep", 8'h02, {6'h00, OSC_RUN_O, ASLEEP_O});
   endtask
   task automatic conclude();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #5000;
      errors++;
      conclude();
   end
   initial begin
      {CLK_I, OP_VALID_I, DEST_I, WAKE_I, WDT_TICK_I, LITERAL_I, FILE_ADDR_I} = '0;
      RESET_I = 1'b1;
      OP_I = SSOPS_NOP;
      errors = 0;
      compares = 0;
      repeat (4) @(posedge CLK_I);
      #1 RESET_I = 1'b0;
      lit_scn();
      file_scn();
      borrow_scn();
      sleep_scn();
      conclude();
   end
endmodule // testbench
